// file: inc/dod_pkg.sv
package dod_pkg;

  // High-byte and prefix patterns of the decoded opcodes
  localparam logic [7:0]  HB_ACC_IMM     = 8'hB9;
  localparam logic [7:0]  HB_ACC_HIGH    = 8'h6A;
  localparam logic [7:0]  HB_ACC_NOSX    = 8'h69;
  localparam logic [7:0]  HB_ACC_VSHIFT  = 8'h6B;
  localparam logic [4:0]  PFX_AUX_MEM    = 5'h00;
  localparam logic [4:0]  PFX_AUX_SHORT  = 5'h16;
  localparam logic [12:0] PFX_AUX_LONG   = 13'h17E1;
  localparam logic [7:0]  HB_PAGE_MEM    = 8'h0D;
  localparam logic [6:0]  PFX_PAGE_IMM   = 7'h5E;
  localparam logic [7:0]  HB_STAT_ZERO   = 8'h0E;
  localparam logic [7:0]  HB_STAT_ONE    = 8'h0F;
  localparam logic [7:0]  HB_MLD_ACC     = 8'h70;
  localparam logic [7:0]  HB_MLD_XFER    = 8'h71;
  localparam logic [7:0]  HB_MLD_MOVE    = 8'h72;
  localparam logic [7:0]  HB_MLD         = 8'h73;
  localparam logic [7:0]  HB_MLD_SUB     = 8'h74;
  localparam logic [7:0]  HB_PMAC        = 8'hA2;
  localparam logic [7:0]  HB_PMAC_MOVE   = 8'hA3;
  localparam logic [7:0]  HB_AUX_MOD     = 8'h8B;
  localparam logic [4:0]  PFX_AUX_PTR    = 5'h11;
  localparam logic [7:0]  HB_MUL         = 8'h54;
  localparam logic [2:0]  PFX_MUL_IMM    = 3'h6;
  localparam logic [7:0]  HB_MUL_ADD     = 8'h50;
  localparam logic [7:0]  HB_MUL_SUB     = 8'h51;
  localparam logic [7:0]  HB_MUL_UNS     = 8'h55;
  localparam logic [7:0]  HB_LJUST       = 8'hA0;
  localparam logic [15:0] W_NEGATE       = 16'hBE02;
  localparam logic [15:0] W_NMI          = 16'hBE52;
  localparam logic [7:0]  HB_OR          = 8'h6D;
  localparam logic [11:0] PFX_OR_SHIFT   = 12'hBFC;
  localparam logic [15:0] W_OR_16        = 16'hBE82;
  localparam logic [15:0] W_PROD_ACC     = 16'hBE03;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;

  // Word and cycle counts
  localparam logic [1:0]  WORDS_ONE      = 2'h1;
  localparam logic [1:0]  WORDS_TWO      = 2'h2;
  localparam logic [2:0]  CYC_ONE        = 3'h1;
  localparam logic [2:0]  CYC_TWO        = 3'h2;
  localparam logic [2:0]  CYC_THREE      = 3'h3;
  localparam logic [2:0]  CYC_FOUR       = 3'h4;
  localparam logic [4:0]  SHIFT_OF_16    = 5'h10;

  // Reset values
  localparam logic [15:0] RST_WORD       = 16'h0000;
  localparam logic [2:0]  RST_CNT        = 3'h0;

  typedef enum logic [5:0] {
    OP_UNKNOWN      = 6'b000000,
    OP_ACC_IMM      = 6'b000001,
    OP_ACC_ZERO     = 6'b000010,
    OP_ACC_HIGH     = 6'b000011,
    OP_ACC_NOSX     = 6'b000100,
    OP_ACC_VSHIFT   = 6'b000101,
    OP_AUX_MEM      = 6'b000110,
    OP_AUX_SHORT    = 6'b000111,
    OP_AUX_LONG     = 6'b001000,
    OP_PAGE_MEM     = 6'b001001,
    OP_PAGE_IMM     = 6'b001010,
    OP_STAT_ZERO    = 6'b001011,
    OP_STAT_ONE     = 6'b001100,
    OP_MLD          = 6'b001101,
    OP_MLD_ACC      = 6'b001110,
    OP_MLD_MOVE     = 6'b001111,
    OP_MLD_XFER     = 6'b010000,
    OP_MLD_SUB      = 6'b010001,
    OP_PMAC         = 6'b010010,
    OP_PMAC_MOVE    = 6'b010011,
    OP_AUX_MOD      = 6'b010100,
    OP_AUX_PTR      = 6'b010101,
    OP_IDLE_SLOT    = 6'b010110,
    OP_MUL          = 6'b010111,
    OP_MUL_IMM      = 6'b011000,
    OP_MUL_ADD      = 6'b011001,
    OP_MUL_SUB      = 6'b011010,
    OP_MUL_UNS      = 6'b011011,
    OP_LJUST        = 6'b011100,
    OP_NEGATE       = 6'b011101,
    OP_NMI          = 6'b011110,
    OP_OR_MEM       = 6'b011111,
    OP_OR_SHIFT     = 6'b100000,
    OP_OR_16        = 6'b100001,
    OP_PROD_ACC     = 6'b100010
  } dod_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT2 = 2'b01,
    ST_BUSY  = 2'b10
  } dod_mode_t;

  typedef struct packed {
    dod_op_t    op;
    logic [1:0] words;
    logic [2:0] cycles;
    logic       has_addr;
  } dod_info_t;

  typedef struct packed {
    logic       valid;
    dod_op_t    op;
    logic [1:0] words;
    logic [2:0] cycles;
    logic [2:0] aux_sel;
    logic [4:0] shift;
    logic [15:0] imm;
    logic       has_addr;
    logic       addr_indirect;
    logic [6:0] addr_field;
  } dod_out_t;

  typedef struct packed {
    dod_mode_t  mode;
    logic       ready;
    logic [2:0] cnt;
    dod_out_t   out;
  } dod_state_t;

  typedef struct packed {
    logic [15:0] data;
  } dod_hold_t;

endpackage

// file: hdl/dod_word_hold.sv
`timescale 1ns/1ps
`default_nettype none
module dod_word_hold (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata
);
  import dod_pkg::*;

  dod_hold_t st;
  dod_hold_t next_st;

  always_comb begin
    next_st = st;
    if (i_wr) begin
      next_st.data = i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st.data <= RST_WORD;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.data;
endmodule
`default_nettype wire

// file: hdl/dod_decoder.sv
// Overview of operation
// - B9xx loads accumulator with 8-bit constant; B900 clears; 1/1.
// - 6A with address clears low half, loads high half; 1 word, 1 cycle.
// - 69 with address clears upper half, loads low half unsigned.
// - 6B loads accumulator shifted by multiplicand register amount.
// - 0000_0 or 1011_0 plus 3-bit select loads aux register; 1/2.
// - BF08..BF0F plus constant word loads aux register; 2 words, 2 cycles.
// - Page pointer from memory (0D) or 9-bit immediate (1011_110); 1/2.
// - 0E and 0F load status word zero and one; 1 word, 2 cycles.
// - 70 loads multiplicand, accumulates product; 73 plain load.
// - 72 loads multiplicand, accumulates, moves word upward; one cycle.
// - 71 loads multiplicand and transfers product to accumulator; 1/1.
// - 74 loads multiplicand and subtracts previous product; 1/1.
// - A2 plus program address word multiplies, accumulates; 2/3.
// - A3 is that multiply-accumulate plus data move.
// - 8B modifies aux registers; 8B88..8B8F selects pointer; 8B00 is idle slot.
// - 54 multiplies by operand; top bits 110 use 13-bit immediate.
// - 50 adds previous product while forming new product.
// - 51 subtracts previous product; 55 forms unsigned product.
// - A0 normalises; BE02 negates; BE52 non-maskable interrupt, 4 cycles.
// - 6D ORs memory; BFCx plus constant ORs shifted constant; 2/2.
// - BE82 plus constant ORs constant shifted by sixteen; 2/2.
// - BE03 copies product register to accumulator; 1/1.
`timescale 1ns/1ps
`default_nettype none
module dod_decoder (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_instr_valid,
  input  wire logic [15:0]      i_instr_word,
  output logic                  o_ready,
  output dod_pkg::dod_out_t     o_dec
);
  import dod_pkg::*;

  dod_state_t  st;
  dod_state_t  next_st;
  logic [15:0] held_word;
  logic        hold_wr;
  dod_info_t   info_new;
  dod_info_t   info_held;

  function automatic dod_info_t mk(input dod_op_t op, input logic [1:0] w,
                                   input logic [2:0] c, input logic a);
    dod_info_t r;
    r.op       = op;
    r.words    = w;
    r.cycles   = c;
    r.has_addr = a;
    return r;
  endfunction

  function automatic dod_info_t decode(input logic [15:0] w);
    logic [7:0] hb;
    logic [7:0] lb;
    dod_info_t  r;
    hb = w[15:8];
    lb = w[7:0];
    r  = mk(OP_UNKNOWN, WORDS_ONE, CYC_ONE, 1'b0);
    if (hb == HB_ACC_IMM) begin
      if (lb == BYTE_ZERO) begin
        r = mk(OP_ACC_ZERO, WORDS_ONE, CYC_ONE, 1'b0);
      end else begin
        r = mk(OP_ACC_IMM, WORDS_ONE, CYC_ONE, 1'b0);
      end
    end else if (hb == HB_ACC_HIGH) begin
      r = mk(OP_ACC_HIGH, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (hb == HB_ACC_NOSX) begin
      r = mk(OP_ACC_NOSX, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (hb == HB_ACC_VSHIFT) begin
      r = mk(OP_ACC_VSHIFT, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (w[15:11] == PFX_AUX_MEM) begin
      r = mk(OP_AUX_MEM, WORDS_ONE, CYC_TWO, 1'b1);
    end else if (w[15:11] == PFX_AUX_SHORT) begin
      r = mk(OP_AUX_SHORT, WORDS_ONE, CYC_TWO, 1'b0);
    end else if (w[15:3] == PFX_AUX_LONG) begin
      r = mk(OP_AUX_LONG, WORDS_TWO, CYC_TWO, 1'b0);
    end else if (hb == HB_PAGE_MEM) begin
      r = mk(OP_PAGE_MEM, WORDS_ONE, CYC_TWO, 1'b1);
    end else if (w[15:9] == PFX_PAGE_IMM) begin
      r = mk(OP_PAGE_IMM, WORDS_ONE, CYC_TWO, 1'b0);
    end else if (hb == HB_STAT_ZERO) begin
      r = mk(OP_STAT_ZERO, WORDS_ONE, CYC_TWO, 1'b1);
    end else if (hb == HB_STAT_ONE) begin
      r = mk(OP_STAT_ONE, WORDS_ONE, CYC_TWO, 1'b1);
    end else if (hb == HB_MLD_ACC) begin
      r = mk(OP_MLD_ACC, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (hb == HB_MLD) begin
      r = mk(OP_MLD, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (hb == HB_MLD_MOVE) begin
      r = mk(OP_MLD_MOVE, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (hb == HB_MLD_XFER) begin
      r = mk(OP_MLD_XFER, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (hb == HB_MLD_SUB) begin
      r = mk(OP_MLD_SUB, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (hb == HB_PMAC) begin
      r = mk(OP_PMAC, WORDS_TWO, CYC_THREE, 1'b1);
    end else if (hb == HB_PMAC_MOVE) begin
      r = mk(OP_PMAC_MOVE, WORDS_TWO, CYC_THREE, 1'b1);
    end else if (hb == HB_AUX_MOD) begin
      if (lb == BYTE_ZERO) begin
        r = mk(OP_IDLE_SLOT, WORDS_ONE, CYC_ONE, 1'b0);
      end else if (lb[7:3] == PFX_AUX_PTR) begin
        r = mk(OP_AUX_PTR, WORDS_ONE, CYC_ONE, 1'b0);
      end else begin
        r = mk(OP_AUX_MOD, WORDS_ONE, CYC_ONE, 1'b1);
      end
    end else if (hb == HB_MUL) begin
      r = mk(OP_MUL, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (w[15:13] == PFX_MUL_IMM) begin
      r = mk(OP_MUL_IMM, WORDS_ONE, CYC_ONE, 1'b0);
    end else if (hb == HB_MUL_ADD) begin
      r = mk(OP_MUL_ADD, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (hb == HB_MUL_SUB) begin
      r = mk(OP_MUL_SUB, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (hb == HB_MUL_UNS) begin
      r = mk(OP_MUL_UNS, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (hb == HB_LJUST) begin
      r = mk(OP_LJUST, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (w == W_NEGATE) begin
      r = mk(OP_NEGATE, WORDS_ONE, CYC_ONE, 1'b0);
    end else if (w == W_NMI) begin
      r = mk(OP_NMI, WORDS_ONE, CYC_FOUR, 1'b0);
    end else if (hb == HB_OR) begin
      r = mk(OP_OR_MEM, WORDS_ONE, CYC_ONE, 1'b1);
    end else if (w[15:4] == PFX_OR_SHIFT) begin
      r = mk(OP_OR_SHIFT, WORDS_TWO, CYC_TWO, 1'b0);
    end else if (w == W_OR_16) begin
      r = mk(OP_OR_16, WORDS_TWO, CYC_TWO, 1'b0);
    end else if (w == W_PROD_ACC) begin
      r = mk(OP_PROD_ACC, WORDS_ONE, CYC_ONE, 1'b0);
    end
    return r;
  endfunction

  // Builds the issue state from the opcode word and, if any, its second word
  function automatic dod_state_t issue(input dod_state_t s,
                                       input logic [15:0] w,
                                       input logic [15:0] w2,
                                       input dod_info_t inf);
    dod_state_t r;
    logic [2:0] stall;
    r                   = s;
    r.out.valid         = 1'b1;
    r.out.op            = inf.op;
    r.out.words         = inf.words;
    r.out.cycles        = inf.cycles;
    r.out.has_addr      = inf.has_addr;
    r.out.aux_sel       = 3'h0;
    r.out.shift         = 5'h00;
    r.out.imm           = RST_WORD;
    r.out.addr_indirect = 1'b0;
    r.out.addr_field    = 7'h00;
    if (inf.has_addr) begin
      r.out.addr_indirect = w[7];
      r.out.addr_field    = w[6:0];
    end
    case (inf.op)
      OP_ACC_IMM, OP_ACC_ZERO: begin
        r.out.imm = {8'h00, w[7:0]};
      end
      OP_AUX_MEM: begin
        r.out.aux_sel = w[10:8];
      end
      OP_AUX_SHORT: begin
        r.out.aux_sel = w[10:8];
        r.out.imm     = {8'h00, w[7:0]};
      end
      OP_AUX_LONG: begin
        r.out.aux_sel = w[2:0];
        r.out.imm     = w2;
      end
      OP_PAGE_IMM: begin
        r.out.imm = {7'h00, w[8:0]};
      end
      OP_PMAC, OP_PMAC_MOVE: begin
        r.out.imm = w2;
      end
      OP_AUX_PTR: begin
        r.out.aux_sel = w[2:0];
      end
      OP_MUL_IMM: begin
        r.out.imm = {{3{w[12]}}, w[12:0]};
      end
      OP_OR_SHIFT: begin
        r.out.shift = {1'b0, w[3:0]};
        r.out.imm   = w2;
      end
      OP_OR_16: begin
        r.out.shift = SHIFT_OF_16;
        r.out.imm   = w2;
      end
      default: begin
        r.out.imm = RST_WORD;
      end
    endcase
    // Stall covers execution cycles beyond those used fetching words
    stall = inf.cycles - {1'b0, inf.words};
    r.cnt = stall;
    if (stall == RST_CNT) begin
      r.mode = ST_IDLE;
    end else begin
      r.mode = ST_BUSY;
    end
    return r;
  endfunction

  dod_word_hold u_hold (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr      (hold_wr),
    .i_wdata   (i_instr_word),
    .o_rdata   (held_word)
  );

  always_comb begin
    info_new  = decode(i_instr_word);
    info_held = decode(held_word);
    hold_wr   = 1'b0;
    next_st   = st;
    next_st.out.valid = 1'b0;
    case (st.mode)
      ST_IDLE: begin
        if (i_instr_valid) begin
          if (info_new.words == WORDS_TWO) begin
            // First word parked until its second word (constant or program address) arrives
            hold_wr      = 1'b1;
            next_st.mode = ST_WAIT2;
          end else begin
            next_st = issue(st, i_instr_word, RST_WORD, info_new);
          end
        end
      end
      ST_WAIT2: begin
        if (i_instr_valid) begin
          next_st = issue(st, held_word, i_instr_word, info_held);
        end
      end
      ST_BUSY: begin
        next_st.cnt = st.cnt - CYC_ONE;
        if (st.cnt == CYC_ONE) begin
          next_st.mode = ST_IDLE;
        end
      end
      default: begin
        next_st.mode = ST_IDLE;
      end
    endcase
    next_st.ready = (next_st.mode != ST_BUSY);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st.mode  <= ST_IDLE;
      st.ready <= 1'b1;
      st.cnt   <= RST_CNT;
      st.out   <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_ready = st.ready;
  assign o_dec   = st.out;

  // Checking helpers
  logic        acc_idle;
  assign acc_idle = (st.mode == ST_IDLE) && i_instr_valid;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_acc_zero_clear: assert property (
    acc_idle && i_instr_word == {HB_ACC_IMM, BYTE_ZERO}
    |=> o_dec.valid && o_dec.op == OP_ACC_ZERO && o_dec.imm == RST_WORD)
    else $error("accumulator clear word not decoded");

  a_acc_high_one: assert property (
    acc_idle && i_instr_word[15:8] == HB_ACC_HIGH
    |=> o_dec.valid && o_dec.op == OP_ACC_HIGH && o_dec.cycles == CYC_ONE
        && o_ready)
    else $error("high accumulator load wrong");

  a_aux_mem_stall: assert property (
    acc_idle && i_instr_word[15:11] == PFX_AUX_MEM
    |=> o_dec.valid && o_dec.aux_sel == $past(i_instr_word[10:8]) && !o_ready
        ##1 o_ready)
    else $error("aux register load timing wrong");

  a_aux_long_pair: assert property (
    acc_idle && i_instr_word[15:3] == PFX_AUX_LONG
    ##1 (i_instr_valid && o_ready && !o_dec.valid)
    |=> o_dec.valid && o_dec.op == OP_AUX_LONG
        && o_dec.imm == $past(i_instr_word) && o_ready)
    else $error("long aux load not paired");

  a_page_imm_field: assert property (
    acc_idle && i_instr_word[15:9] == PFX_PAGE_IMM
    |=> o_dec.op == OP_PAGE_IMM
        && o_dec.imm == {7'h00, $past(i_instr_word[8:0])} && !o_ready)
    else $error("page pointer immediate wrong");

  a_pmac_three: assert property (
    acc_idle && i_instr_word[15:8] == HB_PMAC ##1 i_instr_valid
    |=> o_dec.valid && o_dec.cycles == CYC_THREE && !o_ready ##1 o_ready)
    else $error("program multiply-accumulate timing wrong");

  a_mul_imm_sext: assert property (
    acc_idle && i_instr_word[15:13] == PFX_MUL_IMM
    |=> o_dec.op == OP_MUL_IMM
        && o_dec.imm[12:0] == $past(i_instr_word[12:0])
        && o_dec.imm[15:13] == {3{$past(i_instr_word[12])}})
    else $error("multiply immediate wrong");

  a_nmi_four: assert property (
    acc_idle && i_instr_word == W_NMI
    |=> o_dec.valid ##0 (!o_ready) [*3] ##1 o_ready)
    else $error("interrupt stall length wrong");

  a_or16_shift: assert property (
    acc_idle && i_instr_word == W_OR_16 ##1 i_instr_valid
    |=> o_dec.op == OP_OR_16 && o_dec.shift == SHIFT_OF_16 && o_ready)
    else $error("or with shift of sixteen wrong");

  a_addr_mode_split: assert property (
    acc_idle && i_instr_word[15:8] == HB_OR
    |=> o_dec.has_addr && o_dec.addr_indirect == $past(i_instr_word[7])
        && o_dec.addr_field == $past(i_instr_word[6:0]))
    else $error("address field split wrong");

endmodule
`default_nettype wire

// file: verif/dod_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module dod_fetch_model (
  input  wire logic        i_clk,
  input  wire logic        i_ready,
  input  wire logic        i_slow,
  output logic             o_valid,
  output logic      [15:0] o_word
);
  logic [15:0] q[$];
  logic        taken;

  task automatic push(input logic [15:0] w);
    q.push_back(w);
  endtask

  // One process owns the bus; the take is judged on ready before it updates
  initial begin
    o_valid = 1'b0;
    o_word  = 16'h0000;
    forever begin
      @(posedge i_clk);
      taken = o_valid && i_ready;
      @(negedge i_clk);
      if (taken) begin
        void'(q.pop_front());
      end
      // Idle bus inverts its word on every idle cycle, so the last word shows again on every second one
      if (taken || !o_valid) begin
        if (q.size() > 0 && (!i_slow || $urandom_range(2) == 0)) begin
          o_valid = 1'b1;
          o_word  = q[0];
        end else begin
          o_valid = 1'b0;
          o_word  = ~o_word;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/dod_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dod_decoder_tb_top;
  import dod_pkg::*;
  logic        clk;
  logic        rst;
  logic        slow;
  logic        vld;
  logic [15:0] word;
  logic        ready;
  dod_out_t    dec;
  dod_out_t    exp_q[$];
  dod_out_t    e;
  logic [2:0]  cnt;
  logic [2:0]  stall_exp;
  logic        watching;
  int          num_errors;
  int          checked;
  int          cycles;
  logic [15:0] tbl[] = '{16'hB900, 16'hB9FF, 16'h6A85, 16'h6900, 16'h6B7F,
    16'h0012, 16'h07FF, 16'hB3AB, 16'hBF08, 16'hBF0F, 16'h0D10, 16'hBD5A,
    16'h0E80, 16'h0FFF, 16'h7001, 16'h7102, 16'h7203, 16'h7304, 16'h7405,
    16'hA2C1, 16'hA312, 16'h8B00, 16'h8B80, 16'h8B8F, 16'h8B90, 16'h5401,
    16'hC000, 16'hDFFF, 16'h5002, 16'h5103, 16'h5504, 16'hA0FF, 16'hBE02,
    16'hBE52, 16'h6D33, 16'hBFC0, 16'hBFCF, 16'hBE82, 16'hBE03, 16'h7500,
    16'hBE00, 16'h0C12};

  dod_decoder i_dut (
    .i_clk         (clk),
    .i_sys_rst     (rst),
    .i_instr_valid (vld),
    .i_instr_word  (word),
    .o_ready       (ready),
    .o_dec         (dec)
  );

  dod_fetch_model i_fetch (
    .i_clk   (clk),
    .i_ready (ready),
    .i_slow  (slow),
    .o_valid (vld),
    .o_word  (word)
  );

  function automatic dod_out_t ref_dec(input logic [15:0] w,
                                       input logic [15:0] w2);
    dod_out_t r;
    logic     a;
    r        = '0;
    r.valid  = 1'b1;
    r.op     = OP_UNKNOWN;
    r.words  = WORDS_ONE;
    r.cycles = CYC_ONE;
    a        = 1'b1;
    case (w[15:8])
      8'h6A: r.op = OP_ACC_HIGH;
      8'h69: r.op = OP_ACC_NOSX;
      8'h6B: r.op = OP_ACC_VSHIFT;
      8'h0D: r.op = OP_PAGE_MEM;
      8'h0E: r.op = OP_STAT_ZERO;
      8'h0F: r.op = OP_STAT_ONE;
      8'h70: r.op = OP_MLD_ACC;
      8'h71: r.op = OP_MLD_XFER;
      8'h72: r.op = OP_MLD_MOVE;
      8'h73: r.op = OP_MLD;
      8'h74: r.op = OP_MLD_SUB;
      8'hA2: r.op = OP_PMAC;
      8'hA3: r.op = OP_PMAC_MOVE;
      8'h54: r.op = OP_MUL;
      8'h50: r.op = OP_MUL_ADD;
      8'h51: r.op = OP_MUL_SUB;
      8'h55: r.op = OP_MUL_UNS;
      8'hA0: r.op = OP_LJUST;
      8'h6D: r.op = OP_OR_MEM;
      8'h8B: r.op = OP_AUX_MOD;
      default: a = 1'b0;
    endcase
    if (r.op == OP_PAGE_MEM || r.op == OP_STAT_ZERO || r.op == OP_STAT_ONE)
      r.cycles = CYC_TWO;
    if (r.op == OP_PMAC || r.op == OP_PMAC_MOVE) begin
      r.words  = WORDS_TWO;
      r.cycles = CYC_THREE;
      r.imm    = w2;
    end
    if (w == 16'h8B00) begin
      r.op = OP_IDLE_SLOT;
      a    = 1'b0;
    end else if (w[15:3] == 13'h1171) begin
      r.op      = OP_AUX_PTR;
      r.aux_sel = w[2:0];
      a         = 1'b0;
    end
    if (w[15:8] == 8'hB9) begin
      r.op  = (w[7:0] == 8'h00) ? OP_ACC_ZERO : OP_ACC_IMM;
      r.imm = {8'h00, w[7:0]};
    end else if (w[15:13] == 3'h6) begin
      r.op  = OP_MUL_IMM;
      r.imm = {{3{w[12]}}, w[12:0]};
    end else if (w[15:11] == 5'h00 || w[15:11] == 5'h16) begin
      r.op      = w[15] ? OP_AUX_SHORT : OP_AUX_MEM;
      a         = !w[15];
      r.imm     = w[15] ? {8'h00, w[7:0]} : 16'h0000;
      r.aux_sel = w[10:8];
      r.cycles  = CYC_TWO;
    end else if (w[15:3] == 13'h17E1 || w[15:4] == 12'hBFC ||
                 w == 16'hBE82) begin
      r.op      = w[15:3] == 13'h17E1 ? OP_AUX_LONG :
                  w[15:4] == 12'hBFC ? OP_OR_SHIFT : OP_OR_16;
      r.aux_sel = r.op == OP_AUX_LONG ? w[2:0] : 3'h0;
      r.shift   = r.op == OP_OR_SHIFT ? {1'b0, w[3:0]} :
                  r.op == OP_OR_16 ? SHIFT_OF_16 : 5'h00;
      r.words   = WORDS_TWO;
      r.cycles  = CYC_TWO;
      r.imm     = w2;
    end else if (w[15:9] == 7'h5E) begin
      r.op     = OP_PAGE_IMM;
      r.imm    = {7'h00, w[8:0]};
      r.cycles = CYC_TWO;
    end
    if (w == 16'hBE02) r.op = OP_NEGATE;
    if (w == 16'hBE03) r.op = OP_PROD_ACC;
    if (w == 16'hBE52) begin
      r.op     = OP_NMI;
      r.cycles = CYC_FOUR;
    end
    r.has_addr = a;
    if (a) begin
      r.addr_indirect = w[7];
      r.addr_field    = w[6:0];
    end
    return r;
  endfunction

  task automatic issue(input logic [15:0] w, input logic [15:0] w2);
    dod_out_t r;
    r = ref_dec(w, w2);
    exp_q.push_back(r);
    i_fetch.push(w);
    if (r.words == WORDS_TWO) i_fetch.push(w2);
  endtask

  task automatic drain(input string name);
    int n;
    n = 0;
    while ((exp_q.size() > 0 || watching) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n == 3000) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, exp_q.size(), 0);
    end
    $display("test %s done", name);
  endtask

  task automatic summarize();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Result watcher; stall length is counted from the valid cycle onward
  always @(negedge clk) begin
    if (!rst && dec.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(dec.valid, 1'b0)
      end else begin
        e = exp_q.pop_front();
        case (e.op)
          OP_ACC_IMM, OP_ACC_ZERO, OP_ACC_HIGH, OP_ACC_NOSX, OP_ACC_VSHIFT:
            `CHK(dec, e)
          OP_AUX_MEM, OP_AUX_SHORT, OP_AUX_LONG, OP_PAGE_MEM, OP_PAGE_IMM,
          OP_STAT_ZERO, OP_STAT_ONE: `CHK(dec, e)
          OP_MLD, OP_MLD_ACC, OP_MLD_MOVE, OP_MLD_XFER, OP_MLD_SUB:
            `CHK(dec, e)
          OP_PMAC, OP_PMAC_MOVE, OP_AUX_MOD, OP_AUX_PTR, OP_IDLE_SLOT:
            `CHK(dec, e)
          OP_MUL, OP_MUL_IMM, OP_MUL_ADD, OP_MUL_SUB, OP_MUL_UNS:
            `CHK(dec, e)
          OP_LJUST, OP_NEGATE, OP_NMI, OP_OR_MEM, OP_OR_SHIFT, OP_OR_16,
          OP_PROD_ACC:
            `CHK(dec, e)
          default: `CHK(dec, e)
        endcase
        `CHK(dec.addr_field, e.addr_field)
        stall_exp = e.cycles - {1'b0, e.words};
        cnt       = {2'b00, !ready};
        watching  = !ready;
        if (ready === 1'b1) `CHK(cnt, stall_exp)
      end
    end else if (watching) begin
      if (ready === 1'b1) begin
        watching = 1'b0;
        `CHK(cnt, stall_exp)
      end else begin
        cnt = cnt + 3'h1;
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Cycle ceiling well above the longest slow random run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    logic [15:0] w;
    rst        = 1'b1;
    slow       = 1'b0;
    watching   = 1'b0;
    num_errors = 0;
    checked    = 0;
    cycles     = 0;
    void'($urandom(32'hea9e));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    foreach (tbl[i]) issue(tbl[i], 16'h5A3C ^ 16'(i));
    drain("table");
    for (int k = 0; k < 400; k++) begin
      if (k == 200) begin
        drain("random fast");
        slow = 1'b1;
      end
      w    = 16'($urandom());
      if (k[0]) w[15:8] = tbl[$urandom_range(tbl.size() - 1)][15:8];
      issue(w, 16'($urandom()));
    end
    drain("random slow");
    rst = 1'b1;
    repeat (3) @(negedge clk);
    `CHK({ready, dec}, {1'b1, 45'h0})
    rst = 1'b0;
    issue(16'hBE52, 16'h0000);
    issue(16'hA312, 16'hFFFF);
    drain("reset");
    summarize();
  end
endmodule
`default_nettype wire
